// ---- hw/awr_apb_port.sv ----
// apb slave with staged access to wide table entries
`default_nettype none
`include "awr_defines.svh"
module awr_apb_port #(
  parameter int TIMEOUT = `AWR_TIMEOUT_CYC,
  parameter int ENTRIES = `AWR_WIDE_ENTRIES,
  parameter int WORDS = `AWR_WIDE_WORDS,
  parameter int SLOT_LOG2 = `AWR_WIDE_SLOT_LOG2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`AWR_ADDR_W-1:0] paddr,
  input wire logic [`AWR_DATA_W-1:0] pwdata,
  output logic [`AWR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`AWR_DATA_W-1:0] narrow_cfg
);
  localparam int DW = `AWR_DATA_W;
  localparam int WB = `AWR_WIDE_BITS;
  localparam int IW = $clog2(ENTRIES);

  awr_pkg::awr_state_t state;
  awr_pkg::awr_req_t req;
  logic [WB-1:0] shadow;
  logic [7:0] wait_cnt;
  logic mem_start;
  logic mem_done;
  logic [WB-1:0] mem_rdata;
  logic [WB-1:0] merged;
  logic [DW*WORDS-1:0] shadow_ext;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // slot offset, wide hit and word select are used by several processes
  function automatic logic is_wide(input logic [`AWR_ADDR_W-2:0] a);
    logic [`AWR_ADDR_W-2:0] base;
    logic [`AWR_ADDR_W-2:0] off;
    base = (`AWR_ADDR_W-1)'(`AWR_WIDE_BASE);
    off = a - base;
    is_wide = (a >= base) && ((off >> (SLOT_LOG2 + 2)) < ENTRIES)
      && (int'(off[SLOT_LOG2+1:2]) < WORDS) && (off[1:0] == 2'b00);
  endfunction
  function automatic logic [SLOT_LOG2-1:0] word_sel(input logic [`AWR_ADDR_W-2:0] a);
    word_sel = a[SLOT_LOG2+1:2];
  endfunction
  function automatic logic [IW-1:0] entry_sel(input logic [`AWR_ADDR_W-2:0] a);
    logic [`AWR_ADDR_W-2:0] off;
    off = a - (`AWR_ADDR_W-1)'(`AWR_WIDE_BASE);
    entry_sel = IW'(off >> (SLOT_LOG2 + 2));
  endfunction

  logic hit_wide;
  logic hit_narrow;
  logic [SLOT_LOG2-1:0] wsel;
  assign hit_wide = is_wide(req.addr);
  assign hit_narrow = (req.addr == (`AWR_ADDR_W-1)'(`AWR_NARROW_ADDR));
  assign wsel = word_sel(req.addr);
  assign shadow_ext = (DW*WORDS)'(shadow);

  // merge bus word into shadow copy for a direct write to the table or a staged write to the shadow
  always_comb begin
    logic [DW*WORDS-1:0] tmp;
    tmp = shadow_ext;
    tmp[wsel*DW +: DW] = req.wdata;
    merged = WB'(tmp);
  end

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  // a direct wide access goes to memory; staged wide and direct narrow accesses end at once, the rest by timeout
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= awr_pkg::AWR_IDLE;
      req <= '0;
      wait_cnt <= 8'h00;
      mem_start <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      mem_start <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      unique case (state)
        awr_pkg::AWR_IDLE: begin
          if (psel && !penable) begin
            req.write <= pwrite;
            req.staged <= paddr[`AWR_STAGED_BIT];
            req.addr <= paddr[`AWR_ADDR_W-2:0];
            req.wdata <= pwdata;
            wait_cnt <= 8'h00;
            state <= awr_pkg::AWR_BUSY;
          end
        end
        awr_pkg::AWR_BUSY: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (hit_wide && !req.staged) begin
            if (wait_cnt == 8'h00) begin
              mem_start <= 1'b1;
            end
            if (mem_done) begin
              prdata <= req.write ? 32'h00000000 : DW'(mem_rdata >> (wsel*DW));
              pready <= 1'b1;
              state <= awr_pkg::AWR_DONE;
            end
          end else if (hit_wide) begin
            // staged access served from the shadow alone
            prdata <= req.write ? 32'h00000000 : shadow_ext[wsel*DW +: DW];
            pready <= 1'b1;
            state <= awr_pkg::AWR_DONE;
          end else if (hit_narrow && !req.staged) begin
            prdata <= req.write ? 32'h00000000 : narrow_cfg;
            pready <= 1'b1;
            state <= awr_pkg::AWR_DONE;
          end else if (wait_cnt == 8'(TIMEOUT - 1)) begin
            // no range check: unmapped space only ends by timeout
            prdata <= 32'h00000000;
            pready <= 1'b1;
            pslverr <= 1'b1;
            state <= awr_pkg::AWR_DONE;
          end
        end
        awr_pkg::AWR_DONE: begin
          state <= awr_pkg::AWR_IDLE;
        end
        default: state <= awr_pkg::AWR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // shadow register and narrow register
  // ----------------------------------------
  // shadow loads on direct reads and staged writes only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shadow <= '0;
    end else if (state == awr_pkg::AWR_BUSY && hit_wide) begin
      if (!req.staged && !req.write && mem_done) begin
        shadow <= mem_rdata;
      end else if (req.staged && req.write) begin
        shadow <= merged;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      narrow_cfg <= `AWR_NARROW_RESET;
    end else if (state == awr_pkg::AWR_BUSY && hit_narrow && !req.staged && req.write) begin
      narrow_cfg <= req.wdata;
    end
  end

  // the write carries whatever the shadow holds: no lock against hardware updates
  awr_table #(
    .ENTRIES(ENTRIES),
    .WIDTH(WB),
    .LAT(`AWR_MEM_LAT)
  ) u_table (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(mem_start),
    .wr(req.write),
    .index(entry_sel(req.addr)),
    .wdata(merged),
    .rdata(mem_rdata),
    .done(mem_done)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_err_timeout: assert property (@(posedge ref_clk) disable iff (reset)
    pslverr |-> pready && !$past(hit_wide) && !$past(hit_narrow && !req.staged))
    else $error("pslverr without unmapped access");
  // direct wide accesses wait on the table, not on the timeout, so they are left out here
  chk_timeout_bound: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && !(hit_wide && !req.staged) |-> wait_cnt < 8'(TIMEOUT))
    else $error("transfer exceeded timeout");
  chk_staged_fast: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state == awr_pkg::AWR_BUSY) && hit_wide && req.staged |=> pready && !pslverr)
    else $error("staged access waited");
  chk_staged_noread: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && req.staged |-> !mem_start)
    else $error("staged access touched memory");
  chk_direct_fill: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && hit_wide && !req.staged && !req.write && mem_done
    |=> shadow == $past(mem_rdata))
    else $error("direct read did not fill shadow");
  chk_shadow_read: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && hit_wide && req.staged && !req.write
    |=> prdata == $past(shadow_ext[wsel*DW +: DW]))
    else $error("staged read data mismatch");
  chk_staged_wr: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && hit_wide && req.staged && req.write
    |=> shadow == $past(merged))
    else $error("staged write did not load shadow word");
  chk_hold_shadow: assert property (@(posedge ref_clk) disable iff (reset)
    state == awr_pkg::AWR_BUSY && hit_wide && !req.staged && req.write |=> $stable(shadow))
    else $error("direct write changed shadow");
  chk_direct_lat: assert property (@(posedge ref_clk) disable iff (reset)
    mem_start |-> ##[1:20] mem_done)
    else $error("memory access not completed");
  cov_timeout: cover property (@(posedge ref_clk) pslverr);
  cov_direct_read: cover property (@(posedge ref_clk) mem_done && !req.write);
  cov_direct_write: cover property (@(posedge ref_clk) mem_done && req.write);
  cov_staged: cover property (@(posedge ref_clk) pready && req.staged && hit_wide);
endmodule
`default_nettype wire

// ---- hw/awr_defines.svh ----
// constants for the wide register access port
`ifndef AWR_DEFINES_SVH
`define AWR_DEFINES_SVH
`define AWR_ADDR_W 28
`define AWR_DATA_W 32
`define AWR_STAGED_BIT 27
`define AWR_TIMEOUT_CYC 64
`define AWR_MEM_LAT 12
`define AWR_WIDE_BASE 28'h0001000
`define AWR_WIDE_ENTRIES 16
`define AWR_WIDE_WORDS 3
`define AWR_WIDE_SLOT_LOG2 2
`define AWR_WIDE_BITS 72
`define AWR_NARROW_ADDR 28'h0000010
`define AWR_NARROW_RESET 32'h00000000
`endif

// ---- hw/awr_pkg.sv ----
// types for the wide register access port
`default_nettype none
`include "awr_defines.svh"
package awr_pkg;
  typedef enum logic [1:0] {
    AWR_IDLE = 2'b00,
    AWR_BUSY = 2'b01,
    AWR_DONE = 2'b10
  } awr_state_t;
  typedef struct packed {
    logic write;
    logic staged;
    logic [`AWR_ADDR_W-2:0] addr;
    logic [`AWR_DATA_W-1:0] wdata;
  } awr_req_t;
endpackage
`default_nettype wire

// ---- hw/awr_table.sv ----
// wide table memory with a fixed access latency
`default_nettype none
`include "awr_defines.svh"
module awr_table #(
  parameter int ENTRIES = `AWR_WIDE_ENTRIES,
  parameter int WIDTH = `AWR_WIDE_BITS,
  parameter int LAT = `AWR_MEM_LAT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic wr,
  input wire logic [$clog2(ENTRIES)-1:0] index,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata,
  output logic done
);
  logic [WIDTH-1:0] mem [ENTRIES];
  logic [7:0] cnt;
  logic run;
  // latency counter models the busy arbitration toward the memory
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt <= 8'h00;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run <= 1'b1;
        cnt <= 8'(LAT);
      end else if (run) begin
        if (cnt == 8'h01) begin
          run <= 1'b0;
          done <= 1'b1;
        end
        cnt <= cnt - 8'h01;
      end
    end
  end
  // whole entry written in one cycle, so a write is atomic
  always_ff @(posedge ref_clk) begin
    if (run && cnt == 8'h01) begin
      if (wr) begin
        mem[index] <= wdata;
      end
      rdata <= mem[index];
    end
  end
endmodule
`default_nettype wire

// ---- verif/apb_wide_register_access_bench.sv ----
// self-checking bench for the wide register access port
`default_nettype none
`include "awr_defines.svh"
module apb_wide_register_access_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [27:0] paddr;
  logic [31:0] pwdata, prdata, narrow_cfg, rd;
  int lat, n_fail, comparisons;
  // short timeout keeps unmapped accesses quick
  awr_apb_port #(.TIMEOUT(8)) i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .narrow_cfg(narrow_cfg));
  awr_apb_master i_mst (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // -----------------------------
  // checking helpers
  // -----------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a hung transfer ends the run at once
  task automatic acc(logic wr, logic stg, logic [26:0] a, logic [31:0] wd);
    i_mst.xfer(wr, stg, a, wd, rd, er, lat);
    if (lat < 0) begin
      n_fail++;
      print_verdict();
    end
  endtask
  function automatic logic [26:0] wa(int e, int k);
    return 27'(`AWR_WIDE_BASE + e * 16 + k * 4);
  endfunction
  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_narrow();
    chk("cfg reset", 32'h00000000, narrow_cfg);
    acc(1'b1, 1'b0, 27'h0000010, 32'hA5C30F96);
    chk("cfg", 32'hA5C30F96, narrow_cfg);
    acc(1'b0, 1'b0, 27'h0000010, 32'h0);
    chk("narrow rd", 32'hA5C30F96, rd);
    acc(1'b0, 1'b1, 27'h0000010, 32'h0);
    chk("staged narrow err", 32'h1, 32'(er));
  endtask
  task automatic t_wide(int e);
    logic [31:0] w0, w1;
    w0 = 32'h12345678 ^ 32'(e);
    w1 = 32'h9ABCDEF0 ^ 32'(e);
    acc(1'b1, 1'b1, wa(e, 0), w0);
    acc(1'b1, 1'b1, wa(e, 1), w1);
    acc(1'b1, 1'b0, wa(e, 2), 32'h000000C3);
    acc(1'b0, 1'b0, wa(e, 0), 32'h0);
    chk("w0 direct", w0, rd);
    chk("direct err", 32'h0, 32'(er));
    chk("direct slow", 32'h1, 32'(lat > `AWR_MEM_LAT));
    acc(1'b0, 1'b1, wa(e, 1), 32'h0);
    chk("w1 staged", w1, rd);
    chk("staged fast", 32'h1, 32'(lat < 4));
    acc(1'b0, 1'b1, wa(e, 2), 32'h0);
    chk("w2 staged", 32'h000000C3, rd);
  endtask
  // shadow still holds entry 15 from the last direct read; only word 1 may move
  task automatic t_stage_only();
    acc(1'b1, 1'b1, wa(0, 1), 32'hFFFF0000);
    acc(1'b0, 1'b1, wa(0, 1), 32'h0);
    chk("staged word", 32'hFFFF0000, rd);
    acc(1'b0, 1'b1, wa(0, 0), 32'h0);
    chk("other word", 32'h12345677, rd);
    acc(1'b0, 1'b0, wa(0, 1), 32'h0);
    chk("entry kept", 32'h9ABCDEF0, rd);
  endtask
  // partial update: direct read fills shadow, one direct write changes a word
  task automatic t_snapshot();
    acc(1'b0, 1'b0, wa(15, 0), 32'h0);
    acc(1'b1, 1'b0, wa(15, 1), 32'h5A5A0001);
    acc(1'b0, 1'b1, wa(15, 1), 32'h0);
    chk("old snapshot", 32'h9ABCDEFF, rd);
    acc(1'b0, 1'b0, wa(15, 1), 32'h0);
    chk("merged w1", 32'h5A5A0001, rd);
    acc(1'b0, 1'b1, wa(15, 0), 32'h0);
    chk("merged w0", 32'h12345677, rd);
    acc(1'b0, 1'b1, wa(15, 2), 32'h0);
    chk("merged w2", 32'h000000C3, rd);
  endtask
  task automatic t_unmapped();
    acc(1'b0, 1'b0, wa(3, 3), 32'h0);
    chk("slot gap err", 32'h1, 32'(er));
    chk("timeout wait", 32'h1, 32'(lat > 8));
    acc(1'b1, 1'b0, 27'h0000100, 32'h00000001);
    chk("wr err", 32'h1, 32'(er));
    acc(1'b0, 1'b0, 27'h0000014, 32'h0);
    chk("rd err", 32'h1, 32'(er));
    chk("err data", 32'h0, rd);
    chk("cfg kept", 32'hA5C30F96, narrow_cfg);
  endtask
  initial begin
    n_fail = 0;
    comparisons = 0;
    reset = 1'b1;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_narrow();
    t_wide(0);
    t_wide(15);
    t_stage_only();
    t_snapshot();
    t_unmapped();
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/awr_apb_master.sv ----
// apb master model that issues one transfer at a time
`default_nettype none
module awr_apb_master (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [27:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------
  // bus idle values
  // -----------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 28'h0000000;
    pwdata = 32'h00000000;
  end
  // blocking call keeps issue order, one transfer at a time
  // lat counts rising edges from enable to ready, -1 when the wait runs out
  task automatic xfer(input logic wr, input logic stg, input logic [26:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er, output int lat);
    lat = -1;
    @(negedge ref_clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = {stg, a};
    pwdata = wd;
    @(negedge ref_clk);
    penable = 1'b1;
    for (int i = 1; i < 200 && lat < 0; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) begin
        lat = i;
        rd = prdata;
        er = pslverr;
      end
    end
    @(negedge ref_clk);
    psel = 1'b0;
    penable = 1'b0;
    // released lines show the inverse so stale values never look valid
    paddr = ~paddr;
    pwdata = ~pwdata;
  endtask
endmodule
`default_nettype wire
